// ==== hw/cvt_device.sv ====
// Converter control: conversion timing, nap, power-down, sleep, references.
// Assumes pins synchronous to pclk; power-on reset seen via por_event input.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module cvt_device
    import cvt_pkg::*;
#(
    parameter int NCH = NUM_CH
) (
    input wire logic pclk,
    input wire logic presetn,
    cvt_link_if.device link,
    input wire logic por_event,
    input wire logic [1:0] power_mode_field,
    input wire logic [NCH-1:0] channel_sleep_register,
    input wire logic bandgap_disable,
    input wire logic buffered_reference_pin_disable,
    output logic [NCH-1:0] ch_hold,
    output logic [NCH-1:0] ch_convert,
    output logic [NCH-1:0] ch_standby,
    output logic nap_active,
    output logic pdown_active,
    output logic bandgap_en,
    output logic buffered_reference_pin_en,
    output logic conv_done
);
    typedef struct packed {
        cvt_state_e st;
        logic [CNT_W-1:0] cnt;
        logic start_d;
        logic pd_d;
        logic fld_d;
        logic pd_armed;
        logic busy;
        logic [NCH-1:0] hold;
        logic [NCH-1:0] conv;
        logic [NCH-1:0] sleep;
        logic nap;
        logic pdn;
        logic bg_en;
        logic rb_en;
        logic done;
    } cvt_dev_s;

    cvt_dev_s r_ff, nxt_r;
    logic start_rise, pd_rise, pd_req, glob_rst;
    logic fld_down, fld_rise;

    // Level high now and low in last cycle's copy
    function automatic logic rose_now(input logic now_lvl, input logic was_lvl);
        return now_lvl && !was_lvl;
    endfunction

    assign fld_down = (power_mode_field == POWER_MODE_FIELD_DOWN);
    assign start_rise = rose_now(link.conversion_start_pin, r_ff.start_d);
    // Entering power-down by field counts like a pin rise
    assign fld_rise = rose_now(fld_down, r_ff.fld_d);
    assign pd_rise = rose_now(link.power_down_pin, r_ff.pd_d) || fld_rise;
    assign pd_req = link.power_down_pin || fld_down;
    assign glob_rst = pd_rise && r_ff.pd_armed;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.start_d = link.conversion_start_pin;
        nxt_r.pd_d = link.power_down_pin;
        nxt_r.fld_d = fld_down;
        nxt_r.done = 1'b0;
        nxt_r.bg_en = !bandgap_disable;
        nxt_r.rb_en = !buffered_reference_pin_disable;
        if (pd_rise) begin
            nxt_r.pd_armed = 1'b1;
        end
        if (r_ff.cnt != '0) begin
            nxt_r.cnt = r_ff.cnt - 1'b1;
        end
        if (glob_rst || por_event) begin
            nxt_r = '0;
            nxt_r.st = CVT_POR;
            nxt_r.cnt = CNT_W'(POR_CYC);
            nxt_r.busy = 1'b1;
            nxt_r.start_d = link.conversion_start_pin;
            // Pin history kept so a held pin is no fresh edge
            nxt_r.pd_d = link.power_down_pin;
            nxt_r.fld_d = fld_down;
            nxt_r.bg_en = BANDGAP_EN_RST;
            nxt_r.rb_en = BUFFERED_REFERENCE_PIN_EN_RST;
            nxt_r.sleep = CHANNEL_SLEEP_REGISTER_RST;
        end else begin
            case (r_ff.st)
                CVT_POR: begin
                    if (r_ff.cnt == '0) begin
                        nxt_r.busy = 1'b0;
                        nxt_r.st = pd_req ? CVT_PDOWN : CVT_IDLE;
                        nxt_r.pdn = pd_req;
                    end
                end
                CVT_IDLE, CVT_NAP: begin
                    if (pd_req) begin
                        nxt_r.st = CVT_PDOWN;
                        nxt_r.pdn = 1'b1;
                        nxt_r.nap = 1'b0;
                    end else if (start_rise) begin
                        nxt_r.st = CVT_CONV;
                        nxt_r.hold = ~channel_sleep_register;
                        nxt_r.conv = ~channel_sleep_register;
                        nxt_r.sleep = channel_sleep_register;
                        nxt_r.cnt = CNT_W'(CONV_CYC - 1);
                        nxt_r.busy = 1'b1;
                        nxt_r.nap = 1'b0;
                        nxt_r.pd_armed = 1'b0;
                    end else begin
                        // Sleep pattern follows the register between conversions
                        nxt_r.sleep = channel_sleep_register;
                    end
                end
                CVT_CONV: begin
                    nxt_r.hold = '0;
                    if (r_ff.cnt == '0) begin
                        nxt_r.busy = 1'b0;
                        nxt_r.conv = '0;
                        nxt_r.done = 1'b1;
                        if (pd_req) begin
                            nxt_r.st = CVT_PDOWN;
                            nxt_r.pdn = 1'b1;
                        end else if (link.conversion_start_pin) begin
                            nxt_r.st = CVT_NAP;
                            nxt_r.nap = 1'b1;
                        end else begin
                            nxt_r.st = CVT_IDLE;
                        end
                    end
                end
                CVT_PDOWN: begin
                    if (!pd_req) begin
                        nxt_r.st = CVT_IDLE;
                        nxt_r.pdn = 1'b0;
                    end
                end
                default: nxt_r.st = CVT_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Power-on state: busy high while the reset timer runs
            r_ff <= '{st: CVT_POR, cnt: CNT_W'(POR_CYC), busy: 1'b1,
                      sleep: CHANNEL_SLEEP_REGISTER_RST, bg_en: BANDGAP_EN_RST,
                      rb_en: BUFFERED_REFERENCE_PIN_EN_RST, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.busy = r_ff.busy;
    assign ch_hold = r_ff.hold;
    assign ch_convert = r_ff.conv;
    // Power-down puts every channel in standby
    // per-channel standby
    assign ch_standby = r_ff.sleep | {NCH{r_ff.pdn}};
    assign nap_active = r_ff.nap;
    assign pdown_active = r_ff.pdn;
    assign bandgap_en = r_ff.bg_en;
    assign buffered_reference_pin_en = r_ff.rb_en;
    assign conv_done = r_ff.done;
endmodule
`default_nettype wire

// ==== hw/cvt_pkg.sv ====
// Shared constants and types for the converter control block.
// Assumes a 100 MHz pclk; all times but START_LOW_MAX_NS are turned into cycle counts here.
package cvt_pkg;
    localparam int CLK_NS = 10;
    localparam int CONV_MAX_NS = 725;
    localparam int ACQ_MIN_NS = 465;
    localparam int START_LOW_MIN_NS = 40;
    localparam int START_LOW_MAX_NS = 60;
    localparam int NAP_LOW_MIN_NS = 750;
    localparam int WAKE_MAX_NS = 1000000;
    localparam int POR_NS = 1000;
    // Conversion time rounds down, all other times round up
    localparam int CONV_CYC = CONV_MAX_NS / CLK_NS;
    localparam int ACQ_CYC = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int START_HIGH_CYC = (START_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int NAP_LOW_CYC = (NAP_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (WAKE_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
    localparam int NUM_CH = 4;
    localparam int CNT_W = 20;
    // Power mode field encodings, bits [1:0]
    localparam logic [1:0] POWER_MODE_FIELD_NORMAL = 2'h0;
    localparam logic [1:0] POWER_MODE_FIELD_DOWN = 2'h3;
    // Device control bits after reset: band-gap and buffer enabled
    localparam logic [3:0] CHANNEL_SLEEP_REGISTER_RST = 4'h0;
    localparam logic BANDGAP_EN_RST = 1'b1;
    localparam logic BUFFERED_REFERENCE_PIN_EN_RST = 1'b1;
    // Host register offsets on APB
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CFG = 12'h004;
    localparam logic [11:0] REG_STAT = 12'h008;
    localparam logic [11:0] REG_CNT = 12'h00c;
    typedef enum logic [2:0] {
        CVT_POR, CVT_IDLE, CVT_CONV, CVT_NAP, CVT_PDOWN
    } cvt_state_e;
    typedef enum logic [2:0] {
        HST_WAKE, HST_READY, HST_HIGH, HST_WAITB, HST_LOW, HST_PD
    } cvt_hst_e;
endpackage

// ==== hw/cvt_link_if.sv ====
// Pins between host controller and converter control.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ns
`default_nettype none
interface cvt_link_if;
    logic conversion_start_pin;
    logic power_down_pin;
    logic busy;
    modport device (input conversion_start_pin, input power_down_pin, output busy);
    modport host (output conversion_start_pin, output power_down_pin, input busy);
endinterface
`default_nettype wire

// ==== hw/cvt_host.sv ====
// Host controller: drives start and power-down pins, APB register slave.
// Assumes device on the same pclk through cvt_link_if.
`timescale 1ns/1ns
`default_nettype none
module cvt_host
    import cvt_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    cvt_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        cvt_hst_e st;
        logic [CNT_W-1:0] cnt;
        logic busy_d;
        logic start;
        logic pd;
        logic nap_mode;
        logic conv_req;
        logic [15:0] conv_cnt;
        logic [31:0] rdata;
        logic napped;
    } cvt_hst_s;

    cvt_hst_s r_ff, nxt_r;
    logic acc, wr, busy_fall;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign busy_fall = r_ff.busy_d && !link.busy;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.busy_d = link.busy;
        if (r_ff.cnt != '0) begin
            nxt_r.cnt = r_ff.cnt - 1'b1;
        end
        // APB register access
        if (wr && paddr == REG_CTRL) begin
            nxt_r.conv_req = r_ff.conv_req | pwdata[0];
        end else if (wr && paddr == REG_CFG) begin
            nxt_r.pd = pwdata[0];
            nxt_r.nap_mode = pwdata[1];
        end
        // Read data latched in the setup cycle so it stands at the access edge
        if (psel && !penable && !pwrite) begin
            if (paddr == REG_CFG) begin
                nxt_r.rdata = {30'h0, r_ff.nap_mode, r_ff.pd};
            end else if (paddr == REG_STAT) begin
                nxt_r.rdata = {26'h0, r_ff.st == HST_READY, r_ff.conv_req,
                               1'b0, link.busy, r_ff.napped, r_ff.start};
            end else if (paddr == REG_CNT) begin
                nxt_r.rdata = {16'h0, r_ff.conv_cnt};
            end else begin
                nxt_r.rdata = 32'h0;
            end
        end
        case (r_ff.st)
            HST_WAKE: begin
                if (busy_fall) begin
                    nxt_r.cnt = CNT_W'(WAKE_CYCLES);
                end else if (r_ff.cnt == '0 && !link.busy && !r_ff.busy_d) begin
                    nxt_r.st = HST_READY;
                end
            end
            HST_READY: begin
                if (busy_fall) begin
                    nxt_r.cnt = CNT_W'(WAKE_CYCLES);
                    nxt_r.start = 1'b0;
                    nxt_r.napped = 1'b0;
                    nxt_r.st = HST_WAKE;
                end else if (r_ff.pd) begin
                    nxt_r.st = HST_PD;
                    nxt_r.start = 1'b0;
                end else if (r_ff.conv_req) begin
                    // A request written in this same cycle is kept
                    nxt_r.conv_req = wr && (paddr == REG_CTRL) && pwdata[0];
                    if (r_ff.napped) begin
                        nxt_r.start = 1'b0;
                        nxt_r.cnt = CNT_W'(NAP_LOW_CYC);
                        nxt_r.st = HST_LOW;
                    end else begin
                        nxt_r.start = 1'b1;
                        nxt_r.cnt = CNT_W'(START_HIGH_CYC - 1);
                        nxt_r.st = HST_HIGH;
                    end
                end
            end
            HST_LOW: begin
                if (r_ff.cnt == '0) begin
                    nxt_r.start = 1'b1;
                    nxt_r.napped = 1'b0;
                    nxt_r.cnt = CNT_W'(START_HIGH_CYC - 1);
                    nxt_r.st = HST_HIGH;
                end
            end
            HST_HIGH: begin
                if (r_ff.cnt == '0) begin
                    nxt_r.conv_cnt = r_ff.conv_cnt + 16'h1;
                    // low at 40ns, or held high in nap mode until the next request
                    nxt_r.start = r_ff.nap_mode;
                    nxt_r.st = HST_WAITB;
                end
            end
            HST_WAITB: begin
                if (busy_fall) begin
                    nxt_r.napped = r_ff.nap_mode;
                    nxt_r.st = HST_READY;
                end
            end
            HST_PD: begin
                if (!r_ff.pd) begin
                    nxt_r.cnt = CNT_W'(WAKE_CYCLES);
                    nxt_r.napped = 1'b0;
                    nxt_r.st = HST_WAKE;
                end
            end
            default: nxt_r.st = HST_WAKE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '{st: HST_WAKE, cnt: CNT_W'(WAKE_CYC), default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.conversion_start_pin = r_ff.start;
    assign link.power_down_pin = r_ff.pd;
    assign prdata = r_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
endmodule
`default_nettype wire

// ==== sim/cvt_link_chk.sv ====
// Checker on the start, power-down and busy pins of the link.
// Assumes the same pclk and presetn as both ends.
`timescale 1ns/1ns
`default_nettype none
module cvt_link_chk
    import cvt_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conversion_start_pin,
    input wire logic power_down_pin,
    input wire logic busy,
    input wire logic [1:0] power_mode_field
);
    logic [CNT_W-1:0] run_ff;
    logic [CNT_W-1:0] quiet_ff;
    logic [CNT_W-1:0] low_ff;
    logic conv_ff;
    logic nap_ff;
    logic busy_q;
    logic start_q;
    logic busy_up;
    assign busy_up = busy && !busy_q;
    // Busy length and cause, quiet time since reset or power-down, start low time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= '0;
            quiet_ff <= '0;
            low_ff <= '0;
            conv_ff <= 1'b0;
            nap_ff <= 1'b0;
            // Busy is high through reset, so no false rise follows it
            busy_q <= 1'b1;
            start_q <= 1'b0;
        end else begin
            busy_q <= busy;
            start_q <= conversion_start_pin;
            run_ff <= busy ? run_ff + 1'b1 : '0;
            conv_ff <= busy_up ? start_q : conv_ff;
            quiet_ff <= (power_down_pin || (busy && !(busy_up ? start_q : conv_ff))) ? '0 :
                quiet_ff + 1'b1;
            low_ff <= conversion_start_pin ? '0 : low_ff + 1'b1;
            nap_ff <= (conversion_start_pin && !start_q) ? 1'b0 :
                (busy_q && !busy && conversion_start_pin) ? 1'b1 : nap_ff;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    start_busy_a: assert property ($rose(conversion_start_pin) && !busy && !power_down_pin
        && power_mode_field != POWER_MODE_FIELD_DOWN |=> busy) else $error("start did not raise busy");
    conv_len_a: assert property ($fell(busy) && conv_ff |-> run_ff == CONV_CYC)
        else $error("conversion busy length wrong");
    por_len_a: assert property ($fell(busy) && !conv_ff |-> run_ff >= POR_CYC - 1
        && run_ff <= POR_CYC + 2) else $error("reset busy length wrong");
    pd_defer_a: assert property (busy && conv_ff && $rose(power_down_pin) |=> busy)
        else $error("power-down cut a conversion");
    pd_block_a: assert property (power_down_pin && $past(power_down_pin, 3) && !busy
        |=> !busy) else $error("busy rose in power-down");
    start_width_a: assert property ($rose(conversion_start_pin) |->
        conversion_start_pin[*4]) else $error("start pulse too short");
    pd_nostart_a: assert property (power_down_pin |-> !$rose(conversion_start_pin))
        else $error("start raised in power-down");
    wake_gap_a: assert property ($rose(conversion_start_pin) |->
        quiet_ff >= WAKE_CYCLES - 2) else $error("start before wake time");
    nap_low_a: assert property ($rose(conversion_start_pin) && nap_ff |->
        low_ff >= NAP_LOW_CYC) else $error("start low too short after nap");
    cover property ($fell(busy) && conv_ff);
    cover property ($rose(conversion_start_pin) && nap_ff);
    cover property ($rose(power_down_pin) && busy);
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Bench: host and converter control joined by the link, host driven over APB.
// Assumes the design under hw/ and the link checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cvt_pkg::*;
    localparam int WAKE = 50;
    logic pclk, presetn, psel, penable, pwrite, pready, por_event, bg_dis, rb_dis;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0] power_mode_field;
    logic [3:0] sleep_bits, ch_hold, ch_convert, ch_standby;
    logic nap_active, pdown_active, bandgap_en, buffered_reference_pin_en, conv_done;
    int n_errors, n_compared, n_conv, cyc, run, lows;
    cvt_link_if link();
    cvt_device cvt_device_i (.pclk(pclk), .presetn(presetn), .link(link),
        .por_event(por_event), .power_mode_field(power_mode_field),
        .channel_sleep_register(sleep_bits), .bandgap_disable(bg_dis),
        .buffered_reference_pin_disable(rb_dis), .ch_hold(ch_hold), .ch_convert(ch_convert),
        .ch_standby(ch_standby), .nap_active(nap_active), .pdown_active(pdown_active),
        .bandgap_en(bandgap_en), .buffered_reference_pin_en(buffered_reference_pin_en), .conv_done(conv_done));
    cvt_host #(.WAKE_CYCLES(WAKE)) cvt_host_i (.pclk(pclk), .presetn(presetn),
        .link(link), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr());
    cvt_link_chk #(.WAKE_CYCLES(WAKE)) cvt_link_chk_i (.pclk(pclk), .presetn(presetn),
        .conversion_start_pin(link.conversion_start_pin),
        .power_down_pin(link.power_down_pin), .busy(link.busy),
        .power_mode_field(power_mode_field));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task give_verdict;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        run <= (link.busy && presetn) ? run + 1 : 0;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            give_verdict;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Read data is taken at the access edge
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task wait_busy(input logic v);
        do @(posedge pclk); while (link.busy !== v);
    endtask
    task wait_ready;
        rdat = '0;
        while (rdat[5] !== 1'b1) rd(REG_STAT);
    endtask
    task chk_reset_len;
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk(run >= POR_CYC - 1 && run <= POR_CYC + 2, 1'b1);
    endtask
    task start_conv;
        apb(1'b1, REG_CTRL, 32'h1);
        wait_busy(1'b1);
        chk(ch_hold, 4'(~sleep_bits));
        chk(ch_standby, sleep_bits);
        chk(ch_convert, 4'(~sleep_bits));
        n_conv++;
    endtask
    task end_conv;
        wait_busy(1'b0);
        chk(run, CONV_CYC);
        chk(conv_done, 1'b1);
        chk(ch_convert, 4'h0);
        chk(ch_hold, 4'h0);
    endtask
    task t_reset;
        chk(link.busy, 1'b1);
        chk({bandgap_en, buffered_reference_pin_en}, 2'h3);
        chk(ch_standby, 4'h0);
        presetn <= 1'b1;
        wait_busy(1'b0);
        chk(run >= POR_CYC - 1 && run <= POR_CYC + 2, 1'b1);
        wait_ready;
    endtask
    task t_sleep;
        for (int n = 0; n < 5; n++) begin
            sleep_bits <= (n < 4) ? 4'(1 << n) : 4'h0;
            @(posedge pclk);
            start_conv;
            end_conv;
        end
        rd(REG_CNT);
        chk(rdat[15:0], 16'(n_conv));
    endtask
    task t_refs;
        bg_dis <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({bandgap_en, buffered_reference_pin_en}, 2'h1);
        bg_dis <= 1'b0;
        rb_dis <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({bandgap_en, buffered_reference_pin_en}, 2'h2);
        rb_dis <= 1'b0;
    endtask
    task t_nap;
        apb(1'b1, REG_CFG, 32'h2);
        start_conv;
        end_conv;
        chk({nap_active, link.conversion_start_pin}, 2'h3);
        apb(1'b1, REG_CTRL, 32'h1);
        lows = 0;
        do begin
            @(posedge pclk);
            if (link.conversion_start_pin === 1'b0) lows++;
        end while (link.busy !== 1'b1);
        chk(lows >= NAP_LOW_CYC, 1'b1);
        end_conv;
        apb(1'b1, REG_CFG, 32'h0);
    endtask
    task t_pdown;
        start_conv;
        apb(1'b1, REG_CFG, 32'h1);
        chk(link.busy, 1'b1);
        end_conv;
        @(posedge pclk);
        chk({pdown_active, ch_standby}, 5'h1f);
        apb(1'b1, REG_CFG, 32'h0);
        wait_ready;
        start_conv;
        end_conv;
        apb(1'b1, REG_CFG, 32'h1);
        apb(1'b1, REG_CFG, 32'h0);
        apb(1'b1, REG_CFG, 32'h1);
        chk_reset_len;
        apb(1'b1, REG_CFG, 32'h0);
        wait_ready;
    endtask
    task t_por;
        por_event <= 1'b1;
        @(posedge pclk);
        por_event <= 1'b0;
        chk_reset_len;
        rd(REG_STAT);
        chk(rdat[5], 1'b0);
        repeat (WAKE) @(posedge pclk);
    endtask
    task t_field;
        power_mode_field <= POWER_MODE_FIELD_DOWN;
        repeat (3) @(posedge pclk);
        apb(1'b1, REG_CTRL, 32'h1);
        lows = 0;
        repeat (100) begin
            @(posedge pclk);
            if (link.busy !== 1'b0) lows++;
        end
        chk(lows, 0);
        chk(pdown_active, 1'b1);
        power_mode_field <= POWER_MODE_FIELD_NORMAL;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, por_event, bg_dis, rb_dis} = '0;
        {paddr, pwdata, power_mode_field, sleep_bits} = '0;
        {n_errors, n_compared, n_conv, cyc, run} = '0;
        repeat (20) @(posedge pclk);
        t_reset;
        t_sleep;
        t_refs;
        t_nap;
        t_pdown;
        t_por;
        t_field;
        give_verdict;
    end
endmodule
`default_nettype wire
